// ### gpa_port.sv
/*
 * five-bit general-purpose port with level, pull-enable and direction registers.
 * assumes an 8-bit classic wishbone master in the zero page, pins synchronous to clk_i,
 * and stop-mode levels supplied by the power controller.
 */
`timescale 1ns/100ps
`include "gpa_cfg.svh"
module gpa_port
   import gpa_pkg::*;
#(
   parameter int  PINS         = `GPA_PINS,
   parameter int  CTRL_PINS    = `GPA_CTRL_PINS,
   parameter bit  PIN4_OUTPUT  = 1'b0
)
(
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [`GPA_ADR_W-1:0] wb_adr_i,
   input  wire logic [`GPA_DAT_W-1:0] wb_dat_i,
   input  wire logic                  wb_sel_i,
   output logic      [`GPA_DAT_W-1:0] wb_dat_o,
   output logic                       wb_ack_o,
   input  wire logic [PINS-1:0]       pin_in_i,
   output logic      [PINS-1:0]       pin_out_o,
   output logic      [PINS-1:0]       pin_oe_o,
   output logic      [PINS-1:0]       pull_en_o,
   output logic      [PINS-1:0]       in_buf_en_o,
   input  wire logic [PINS-1:0]       periph_oe_en_i,
   input  wire logic [PINS-1:0]       periph_oe_i,
   input  wire logic [PINS-1:0]       periph_out_i,
   input  wire logic [PINS-1:0]       analog_en_i,
   input  wire logic                  stop_power_off_i,
   input  wire logic                  stop_retained_i
);

   // ----------------------------------------
   // elaboration checks
   // ----------------------------------------
   if (PINS != `GPA_PINS || CTRL_PINS != `GPA_CTRL_PINS)
   begin : g_bad_pins
      $error("gpa_port: register layout serves only the documented pin counts");
   end

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   function automatic gpa_reg_t reg_decode(input logic [`GPA_ADR_W-1:0] adr);
      gpa_reg_t sel;
      sel = REG_NONE;
      case (adr)                              // full zero-page decode [R16]
         `GPA_OFS_LEVEL: sel = REG_LEVEL;
         `GPA_OFS_PULL:  sel = REG_PULL;
         `GPA_OFS_DIR:   sel = REG_DIR;
         default:        sel = REG_NONE;
      endcase
      return sel;
   endfunction : reg_decode

   gpa_reg_t                 acc_reg;
   gpa_mode_t                mode;
   gpa_mode_t                next_mode;
   logic [PINS-1:0]          port_a_level;
   logic [CTRL_PINS-1:0]     port_a_pull_enable;
   logic [CTRL_PINS-1:0]     port_a_direction;
   wire                      bus_req;
   wire                      wr_take;
   wire                      wr_ok;
   wire  [PINS-1:0]          dir_eff;
   wire  [PINS-1:0]          pull_eff;
   wire  [PINS-1:0]          ibe_eff;
   wire  [PINS-1:0]          level_rd;
   logic [`GPA_DAT_W-1:0]    next_rd;

   assign acc_reg  = reg_decode(wb_adr_i);
   assign bus_req  = wb_cyc_i & wb_stb_i;
   // write lands on the edge where the master sees ack
   assign wr_take  = bus_req & wb_we_i & wb_sel_i & wb_ack_o;
   // the core is halted in either stop mode, so stray writes are dropped
   assign wr_ok    = wr_take & ~stop_power_off_i & ~stop_retained_i;

   // ----------------------------------------
   // operating mode
   // ----------------------------------------
   always_comb
   begin
      next_mode = MODE_RUN;
      case ({stop_power_off_i, stop_retained_i})
         2'b00:   next_mode = MODE_RUN;
         2'b01:   next_mode = MODE_RETAIN;
         default: next_mode = MODE_OFF;   // power-off wins
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         mode <= MODE_RUN;
      else
         mode <= next_mode;
   end

   // ----------------------------------------
   // port registers
   // ----------------------------------------
   // power-off clears exactly like reset: the registers lose their supply
   always_ff @(posedge clk_i)
   begin
      if (rst_i || stop_power_off_i)
      begin
         port_a_level       <= `GPA_RST_LEVEL;                       // [R5] [R13]
         port_a_pull_enable <= `GPA_RST_PULL;                        // [R6]
         port_a_direction   <= `GPA_RST_DIR;                         // [R6]
      end
      else if (wr_ok)
      begin
         case (acc_reg)
            REG_LEVEL: port_a_level       <= wb_dat_i[PINS-1:0];      // [R3] [R21]
            REG_PULL:  port_a_pull_enable <= wb_dat_i[CTRL_PINS-1:0]; // [R7] [R21]
            REG_DIR:   port_a_direction   <= wb_dat_i[CTRL_PINS-1:0]; // [R10] [R21]
            default:   port_a_level       <= port_a_level;
         endcase
      end
   end

   // ----------------------------------------
   // effective pin controls
   // ----------------------------------------
   // pin four has no stored direction; its use is fixed by PIN4_OUTPUT
   assign dir_eff  = {PIN4_OUTPUT, port_a_direction};                 // [R11] [R12]
   assign pull_eff = {1'b0, port_a_pull_enable};
   assign ibe_eff  = ~analog_en_i & {PINS{~stop_power_off_i}};

   // outputs read back the latch, inputs the pin through its buffer
   assign level_rd = (dir_eff & port_a_level)                         // [R2]
                   | (~dir_eff & ibe_eff & pin_in_i);                 // [R1] [R9] [R20]

   always_comb
   begin
      next_rd = 8'h00;                                                // [R21]
      case (acc_reg)
         REG_LEVEL: next_rd[PINS-1:0]      = level_rd;
         REG_PULL:  next_rd[CTRL_PINS-1:0] = port_a_pull_enable;
         REG_DIR:   next_rd[CTRL_PINS-1:0] = port_a_direction;        // [R10] [R11]
         default:   next_rd = 8'h00;
      endcase
   end

   // ----------------------------------------
   // wishbone slave: one wait state, unmapped reads give zero
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 8'h00;
      end
      else
      begin
         wb_ack_o <= bus_req & ~wb_ack_o;
         // data stands only with ack, zero otherwise
         wb_dat_o <= (bus_req & ~wb_we_i & ~wb_ack_o) ? next_rd : 8'h00;
      end
   end

   // ----------------------------------------
   // pin cells
   // ----------------------------------------
   for (genvar i = 0; i < PINS; i++)
   begin : g_pin
      gpa_pin u_pin (
         .clk_i          (clk_i),
         .rst_i          (rst_i),
         .latch_i        (port_a_level[i]),
         .dir_i          (dir_eff[i]),
         .pull_req_i     (pull_eff[i]),
         .periph_oe_en_i (periph_oe_en_i[i]),
         .periph_oe_i    (periph_oe_i[i]),
         .periph_out_i   (periph_out_i[i]),
         .analog_i       (analog_en_i[i]),
         .off_i          (stop_power_off_i),
         .hold_i         (stop_retained_i),   // [R15]
         .pin_out_o      (pin_out_o[i]),
         .pin_oe_o       (pin_oe_o[i]),
         .pull_en_o      (pull_en_o[i]),
         .in_buf_en_o    (in_buf_en_o[i])
      );
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   wire rd_level = bus_req & ~wb_we_i & (acc_reg == REG_LEVEL) & ~wb_ack_o;
   wire rd_dir   = bus_req & ~wb_we_i & (acc_reg == REG_DIR) & ~wb_ack_o;
   wire run_now  = ~stop_power_off_i & ~stop_retained_i;

   sequence level_read_s;
      rd_level && run_now ##1 wb_ack_o;
   endsequence

   sequence level_write_s;
      wr_take && (acc_reg == REG_LEVEL) && run_now;
   endsequence

   property level_read_p;
      @(posedge clk_i) disable iff (rst_i)
      level_read_s |-> wb_dat_o[PINS-1:0] ==
         (($past(dir_eff) & $past(port_a_level))
          | (~$past(dir_eff) & ~$past(analog_en_i) & $past(pin_in_i)));
   endproperty

   level_read_a: assert property (level_read_p) // [R1] [R2] [R20]
      else $error("level read returned wrong source");

   latch_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
      level_write_s |=> port_a_level == $past(wb_dat_i[PINS-1:0]))
      else $error("level write not latched");

   // expected buffer owner per pin: analog, then shared function, then direction
   wire [CTRL_PINS-1:0] pin_oe_o_next_lo = ~analog_en_i[CTRL_PINS-1:0]
      & ((periph_oe_en_i[CTRL_PINS-1:0] & periph_oe_i[CTRL_PINS-1:0])
         | (~periph_oe_en_i[CTRL_PINS-1:0] & port_a_direction));

   drive_latch_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R4] [R9] [R19]
      run_now |=> pin_oe_o[CTRL_PINS-1:0] == $past(pin_oe_o_next_lo))
      else $error("output enable does not follow direction");

   out_value_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
      run_now && (periph_oe_en_i == 5'h00) && (analog_en_i == 5'h00) |=>
         pin_out_o == $past(port_a_level))
      else $error("pin not driven from latch");

   reset_defaults_a: assert property (@(posedge clk_i) // [R5] [R6]
      rst_i |=> port_a_level == 5'h00 && port_a_direction == 4'h0
         && port_a_pull_enable == 4'h0 && pin_oe_o == 5'h00 && pull_en_o == 5'h00)
      else $error("reset defaults wrong");

   pull_gate_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R7] [R8]
      run_now |=> pull_en_o[CTRL_PINS-1:0] == ($past(port_a_pull_enable)
         & ~$past(pin_oe_o_next_lo) & ~$past(analog_en_i[CTRL_PINS-1:0])))
      else $error("pullup gating wrong");

   dir_readback_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R10] [R11]
      rd_dir ##1 wb_ack_o |-> wb_dat_o == {4'h0, $past(port_a_direction)})
      else $error("direction readback wrong");

   power_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
      stop_power_off_i [*2] |-> port_a_level == 5'h00 && pin_oe_o == 5'h00
         && pull_en_o == 5'h00 && in_buf_en_o == 5'h00)
      else $error("power-off stop left port active");

   retained_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
      stop_retained_i && !stop_power_off_i ##1 stop_retained_i && !stop_power_off_i
         |-> $stable(port_a_level) && $stable(port_a_direction) && $stable(pin_oe_o)
             && $stable(pin_out_o) && $stable(pull_en_o))
      else $error("retained stop changed state");

   reserved_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R21]
      wb_ack_o |-> wb_dat_o[`GPA_DAT_W-1:PINS] == 3'h0)
      else $error("reserved bits read nonzero");

   ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held more than one cycle");

   mode_track_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
      stop_power_off_i |=> mode == MODE_OFF)
      else $error("mode did not enter power-off");

   ack_timing_a: assert property (@(posedge clk_i) disable iff (rst_i)
      bus_req && !wb_ack_o |=> wb_ack_o)
      else $error("ack not given one cycle after request");

   dat_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !wb_ack_o |-> wb_dat_o == 8'h00)
      else $error("read data outside ack cycle");

   sel_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
      bus_req && wb_we_i && !wb_sel_i && wb_ack_o && !stop_power_off_i
         |=> $stable(port_a_level) && $stable(port_a_pull_enable)
             && $stable(port_a_direction))
      else $error("unselected write changed a register");

   unmapped_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
      bus_req && wb_we_i && wb_ack_o && (acc_reg == REG_NONE) && !stop_power_off_i
         |=> $stable(port_a_level) && $stable(port_a_pull_enable)
             && $stable(port_a_direction))
      else $error("unmapped write changed a register");

   unmapped_read_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R16] [R21]
      bus_req && !wb_we_i && (acc_reg == REG_NONE) && !wb_ack_o |=> wb_dat_o == 8'h00)
      else $error("unmapped read returned nonzero");

   pin_four_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R11] [R12]
      !PIN4_OUTPUT && !periph_oe_en_i[`GPA_PIN_FOUR] && !stop_retained_i
         |=> !pin_oe_o[`GPA_PIN_FOUR])
      else $error("pin four driven while fixed as input");

endmodule : gpa_port

// ### gpa_cfg.svh
/*
 * constants of the five-bit general-purpose port: offsets, widths, reset values.
 * assumes an 8-bit classic wishbone register bus decoded within the zero page.
 */
// What this block does
// R1 - input pin: level read returns pin
// R2 - output pin: level read returns latch
// R3 - level write updates all latch bits
// R4 - output pin driven from its latch bit
// R5 - reset clears latch, pins stay inputs
// R6 - reset: inputs, high impedance, pullups off
// R7 - pull-enable bit one turns pullup on
// R8 - output pin keeps pullup off always
// R9 - direction zero: driver off, read pin
// R10 - direction bits readable and writable
// R11 - pin four direction bit reads zero
// R12 - pin four usable as output only; the code fixes its use by PIN4_OUTPUT, input-only by default
// R13 - power-off stop: registers cleared, buffers off
// R14 - software reprograms port after power-off stop
// R15 - retained stop holds pins and registers
// R16 - port registers decoded in zero page
// R17 - software keeps unused pins from floating
// R18 - software keeps rail-tied pins as inputs
// R19 - shared peripheral overrides port output control
// R20 - analog input pin reads zero
// R21 - reserved bits read zero, writes ignored
`ifndef GPA_CFG_SVH
`define GPA_CFG_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define GPA_ADR_W       8
`define GPA_DAT_W       8
`define GPA_OFS_LEVEL   8'h00
`define GPA_OFS_PULL    8'h01
`define GPA_OFS_DIR     8'h03

// ----------------------------------------
// field layout and reset values
// ----------------------------------------
`define GPA_PINS        5
`define GPA_CTRL_PINS   4
`define GPA_PIN_FOUR    4
`define GPA_RST_LEVEL   5'h00
`define GPA_RST_PULL    4'h0
`define GPA_RST_DIR     4'h0

`endif

// ### gpa_pkg.sv
/*
 * types shared by the port block and its pin cell.
 * assumes nothing beyond the constants header.
 */
package gpa_pkg;

   // ----------------------------------------
   // register select and operating mode
   // ----------------------------------------
   typedef enum logic [1:0] {REG_LEVEL, REG_PULL, REG_DIR, REG_NONE} gpa_reg_t;
   typedef enum logic [1:0] {MODE_RUN, MODE_RETAIN, MODE_OFF} gpa_mode_t;

endpackage : gpa_pkg

// ### gpa_pin.sv
/*
 * one pin cell: output buffer, output value, pullup and input buffer control.
 * assumes shared functions arrive as per-pin override levels from outside.
 */
`timescale 1ns/100ps
module gpa_pin
   import gpa_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic latch_i,
   input  wire logic dir_i,
   input  wire logic pull_req_i,
   input  wire logic periph_oe_en_i,
   input  wire logic periph_oe_i,
   input  wire logic periph_out_i,
   input  wire logic analog_i,
   input  wire logic off_i,
   input  wire logic hold_i,
   output logic      pin_out_o,
   output logic      pin_oe_o,
   output logic      pull_en_o,
   output logic      in_buf_en_o
);

   // ----------------------------------------
   // buffer selection
   // ----------------------------------------
   wire next_oe;
   wire next_out;
   wire next_pull;
   wire next_ibe;

   // analog wins over shared digital, which wins over the port
   assign next_oe   = analog_i ? 1'b0 : (periph_oe_en_i ? periph_oe_i : dir_i);  // [R19] [R9]
   assign next_out  = analog_i ? 1'b0 : (periph_oe_en_i ? periph_out_i : latch_i); // [R4]
   assign next_pull = pull_req_i & ~next_oe & ~analog_i;                          // [R7] [R8]
   assign next_ibe  = ~analog_i;

   // ----------------------------------------
   // pin drive registers
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i || off_i)
      begin
         pin_out_o   <= 1'b0;  // [R6] [R13]
         pin_oe_o    <= 1'b0;
         pull_en_o   <= 1'b0;
         in_buf_en_o <= 1'b0;
      end
      else if (!hold_i)
      begin
         pin_out_o   <= next_out;
         pin_oe_o    <= next_oe;
         pull_en_o   <= next_pull;
         in_buf_en_o <= next_ibe;
      end
   end

endmodule : gpa_pin

// ### gpa_port_bench.sv
/*
 * self-checking bench for the five-bit general-purpose port.
 * assumes the design's default parameters and a one-cycle registered wishbone ack.
 */
`timescale 1ns/100ps
`include "gpa_cfg.svh"
module gpa_port_bench
   import gpa_pkg::*;
   ;

   // ----------------------------------------
   // stimulus and design
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] dir, pull, lvl;
      logic [4:0] pin;
      logic [7:0] rd;
      logic [4:0] oe, pu, out;
   } gpa_row_t;

   logic       clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic       wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
   logic       wb_sel = 1'b0, sel_v = 1'b1;
   logic [7:0] wb_adr = 8'h00, wb_dat = 8'h00;
   logic [7:0] wb_dat_o;
   logic       wb_ack_o;
   logic [4:0] pin_in = 5'h00, pin_out_o, pin_oe_o, pull_en_o, in_buf_en_o;
   logic [4:0] p_oe_en = 5'h00, p_oe = 5'h00, p_out = 5'h00, analog = 5'h00;
   logic       st_off = 1'b0, st_ret = 1'b0;
   int         bad_count = 0, total_checks = 0, cycles = 0;
   logic [7:0] rdat;
   gpa_row_t   rows [4] = '{
      '{8'hF0, 8'hFF, 8'hFF, 5'h0A, 8'h0A, 5'h00, 5'h0F, 5'h00},
      '{8'hFF, 8'hFF, 8'hF5, 5'h0A, 8'h05, 5'h0F, 5'h00, 5'h05},
      '{8'h05, 8'h0A, 8'h0A, 5'h1F, 8'h1A, 5'h05, 5'h0A, 5'h00},
      '{8'hEA, 8'h05, 8'h1F, 5'h00, 8'h0A, 5'h0A, 5'h05, 5'h0A}};

   always #50 clk_i = ~clk_i;

   gpa_port i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_in_i(pin_in),
      .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .pull_en_o(pull_en_o),
      .in_buf_en_o(in_buf_en_o), .periph_oe_en_i(p_oe_en), .periph_oe_i(p_oe),
      .periph_out_i(p_out), .analog_en_i(analog), .stop_power_off_i(st_off),
      .stop_retained_i(st_ret));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : tally_and_finish

   task chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // request held until ack is sampled, data taken at that same edge
   task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we  <= w;
      wb_sel <= sel_v;
      wb_adr <= a;
      wb_dat <= d;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1 && n < 20)
      begin
         @(posedge clk_i);
         n++;
      end
      if (n == 20)
         chk(8'hEE, 8'hAC);
      rdat = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we  <= 1'b0;
      wb_sel <= 1'b0;
   endtask : wb

   task rd_chk(input logic [7:0] a, input logic [7:0] exp);
      wb(1'b0, a, 8'h00);
      chk(rdat, exp);
   endtask : rd_chk

   // pin cells lag the registers by one edge
   task pins_chk(input logic [4:0] oe, input logic [4:0] pu, input logic [4:0] out,
                 input logic [4:0] ib);
      repeat (3) @(posedge clk_i);
      chk({3'h0, pin_oe_o}, {3'h0, oe});
      chk({3'h0, pull_en_o}, {3'h0, pu});
      chk({3'h0, pin_out_o & pin_oe_o}, {3'h0, out});
      chk({3'h0, in_buf_en_o}, {3'h0, ib});
   endtask : pins_chk

   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         bad_count++;
         tally_and_finish();
      end
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      pins_chk(5'h00, 5'h00, 5'h00, 5'h1F);
      rd_chk(`GPA_OFS_LEVEL, 8'h00);
      rd_chk(`GPA_OFS_PULL, 8'h00);
      rd_chk(`GPA_OFS_DIR, 8'h00);
      // latch written first, so its value is in place before the driver turns on
      foreach (rows[i])
      begin
         pin_in <= rows[i].pin;
         wb(1'b1, `GPA_OFS_LEVEL, rows[i].lvl);
         wb(1'b1, `GPA_OFS_PULL, rows[i].pull);
         wb(1'b1, `GPA_OFS_DIR, rows[i].dir);
         rd_chk(`GPA_OFS_LEVEL, rows[i].rd);
         rd_chk(`GPA_OFS_PULL, rows[i].pull & 8'h0F);
         rd_chk(`GPA_OFS_DIR, rows[i].dir & 8'h0F);
         pins_chk(rows[i].oe, rows[i].pu, rows[i].out, 5'h1F);
      end
      // unmapped places: full decode, no aliasing
      wb(1'b1, 8'h02, 8'hFF);
      wb(1'b1, 8'h83, 8'h00);
      // byte select low: acked but dropped
      sel_v = 1'b0;
      wb(1'b1, `GPA_OFS_DIR, 8'h00);
      sel_v = 1'b1;
      rd_chk(8'h02, 8'h00);
      rd_chk(`GPA_OFS_DIR, 8'h0A);
      // analog and shared function overrides
      pin_in  <= 5'h1F;
      analog  <= 5'h01;
      p_oe_en <= 5'h04;
      p_oe    <= 5'h04;
      p_out   <= 5'h00;
      pins_chk(5'h0E, 5'h00, 5'h0A, 5'h1E);
      rd_chk(`GPA_OFS_LEVEL, 8'h1E);
      analog  <= 5'h00;
      p_oe_en <= 5'h00;
      pin_in  <= 5'h00;
      // one edge so the pins shed the overrides before the freeze
      @(posedge clk_i);
      // retained stop drops writes and freezes pins
      st_ret <= 1'b1;
      wb(1'b1, `GPA_OFS_LEVEL, 8'h00);
      wb(1'b1, `GPA_OFS_DIR, 8'h00);
      pins_chk(5'h0A, 5'h05, 5'h0A, 5'h1F);
      st_ret <= 1'b0;
      rd_chk(`GPA_OFS_DIR, 8'h0A);
      rd_chk(`GPA_OFS_LEVEL, 8'h0A);
      // power-off stop: everything back to reset state
      st_off <= 1'b1;
      pins_chk(5'h00, 5'h00, 5'h00, 5'h00);
      st_off <= 1'b0;
      rd_chk(`GPA_OFS_DIR, 8'h00);
      rd_chk(`GPA_OFS_PULL, 8'h00);
      rd_chk(`GPA_OFS_LEVEL, 8'h00);
      // reprogram: pins 0,1 unused and pulled up, pins 2,3 rail-tied inputs
      wb(1'b1, `GPA_OFS_PULL, 8'h03);
      pins_chk(5'h00, 5'h03, 5'h00, 5'h1F);
      // second reset in mid-run
      wb(1'b1, `GPA_OFS_DIR, 8'h0F);
      wb(1'b1, `GPA_OFS_LEVEL, 8'h1F);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      pins_chk(5'h00, 5'h00, 5'h00, 5'h1F);
      rd_chk(`GPA_OFS_DIR, 8'h00);
      tally_and_finish();
   end

endmodule : gpa_port_bench
